// file: shared/usb_pin_pkg.sv
`default_nettype none
package usb_pin_pkg;
	// Pin function codes for the shared pins
	typedef enum logic [2:0] {
		FN_MODEM   = 3'h0,
		FN_TX_LED  = 3'h1,
		FN_RX_LED  = 3'h2,
		FN_SUSPEND = 3'h3,
		FN_CFG     = 3'h4,
		FN_TXEN    = 3'h5,
		FN_CHGDET  = 3'h6,
		FN_CHGSHDN = 3'h7
	} pin_fn_t;

	// Per-pin configuration
	typedef struct packed {
		pin_fn_t fn;
		logic    invert;
		logic    open_drain;
	} pin_cfg_t;

	// Loaded configuration image
	typedef struct packed {
		logic     sense_en;
		logic     self_powered;
		logic     susp_only;
		logic     i2c_sel;
		pin_cfg_t a4;
		pin_cfg_t a5;
		pin_cfg_t a6;
		pin_cfg_t b6;
	} dev_cfg_t;

	// USB state reported by the core
	typedef struct packed {
		logic configured;
		logic suspended;
		logic charge_port;
	} usb_state_t;

	localparam int CFG_W        = $bits(dev_cfg_t);
	localparam int EE_BYTES     = 256;
	localparam int EE_AW        = 8;
	localparam int SIG_ADDR     = 0;
	localparam int CFG_ADDR     = 1;
	localparam int CFG_BYTES    = 4;
	localparam logic [7:0] SIG_VALUE = 8'h5A;
	localparam int BAUD_MIN     = 1;
	localparam int BAUD_MAX     = 115200;
	localparam int SYNC_STAGES  = 3;
endpackage
`default_nettype wire

// file: verilog/usb_state_pin_signaling.sv
`default_nettype none
// Contract
// - Sense enabled: attach pull-up only while bus-power sense active.
// - Sense disabled: attach pull-up always after power-on; here only once cfg_done is set, after the loader finishes.
// - Report self-powered only when config says self-powered.
// - Charger setup 1: charge detect and configured pins inverted open-drain.
// - Setup 1: shutdown 0 in suspend; 1/1/1 unconfigured; cfg 0; detect 0.
// - Setup 2: suspend/cfg 1/1, 0/0, 0/1, 1/0 per state.
// - Suspend-only option: suspend output only during bus suspend.
// - Default config asserts suspend output during USB suspend.
// - Transmit enable asserted only while serial data transmits.
// - Two shared pins may act as transmit and receive activity LEDs.
// - EEPROM support only when data pins assigned as SDA and SCL.
// - Load EEPROM contents only when signature valid, overriding ROM.
// - EEPROM is 256 bytes; loader reads only addresses 0 to 4.
// - Serial port supports 1 to 115200 bps.
// - Default suspend output active when unconfigured or suspended.
// - Inverse polarity inverts input and output sense of pin.
// - Open-drain pins only drive low, release for high.
module usb_state_pin_signaling
	import usb_pin_pkg::*;
#(
	parameter logic [CFG_W-1:0] ROM_CFG = '0
) (
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire usb_state_t       usb_state,
	input  wire logic             tx_active,
	input  wire logic             rx_active,
	input  wire logic             bus_power_sense,
	input  wire logic             ee_rd_ack,
	input  wire logic [7:0]       ee_rd_data,
	input  wire logic             ee_nack,
	input  wire logic [3:0]       pin_in,
	input  wire logic [3:0]       modem_out,
	input  wire logic [31:0]      baud_req,
	output logic                  dp_pullup_en,
	output logic                  self_powered,
	output logic                  ee_rd_req,
	output logic [EE_AW-1:0]      ee_rd_addr,
	output logic                  cfg_done,
	output logic                  baud_ok,
	output logic [3:0]            modem_in,
	output logic [3:0]            pin_out,
	output logic [3:0]            pin_oe
);
	// Loader states, Gray coded along the path
	typedef enum logic [1:0] {
		LD_IDLE = 2'b00,
		LD_SIG  = 2'b01,
		LD_DATA = 2'b11,
		LD_DONE = 2'b10
	} ld_state_t;

	localparam dev_cfg_t ROM = dev_cfg_t'(ROM_CFG);

	ld_state_t                st_r, st_nxt;
	dev_cfg_t                 cfg_r, cfg_nxt;
	logic [CFG_BYTES*8-1:0]   img_r, img_nxt;
	logic [EE_AW-1:0]         addr_r, addr_nxt;
	logic                     req_r, req_nxt;
	logic [SYNC_STAGES-1:0]   sense_sync_r;
	logic                     sense_r, sense_nxt;
	// Registered copies of the data outputs and the pin input chain
	logic                     baud_r, baud_nxt;
	logic [3:0]               pin_s0_r, pin_s1_r, pin_s2_r;
	logic [3:0]               pin_lvl_r, pin_lvl_nxt;
	logic [3:0]               mdm_r, mdm_nxt;
	logic [3:0]               out_r, out_nxt;
	logic [3:0]               oe_r, oe_nxt;
	logic [3:0]               lvl;
	pin_cfg_t                 pcfg [4];

	// Map one pin's function to its active-sense level
	function automatic logic fn_level(input pin_fn_t fn,
		input logic modem, input dev_cfg_t c, input usb_state_t s,
		input logic tx, input logic rx);
		logic susp;
		susp = s.suspended || (!c.susp_only && !s.configured);
		case (fn)
			FN_MODEM:   fn_level = modem;
			FN_TX_LED:  fn_level = tx;
			FN_RX_LED:  fn_level = rx;
			FN_SUSPEND: fn_level = !susp;  // low = suspend
			FN_CFG:     fn_level = s.configured;
			FN_TXEN:    fn_level = tx;
			FN_CHGDET:  fn_level = s.charge_port;
			FN_CHGSHDN: fn_level = !s.suspended;
			default:    fn_level = modem;
		endcase
	endfunction

	// Loader next state: signature then config image, else keep ROM
	always_comb begin
		st_nxt   = st_r;
		cfg_nxt  = cfg_r;
		img_nxt  = img_r;
		addr_nxt = addr_r;
		req_nxt  = req_r;
		case (st_r)
			LD_IDLE: begin
				if (ROM.i2c_sel) begin
					st_nxt   = LD_SIG;
					addr_nxt = EE_AW'(SIG_ADDR);
					req_nxt  = 1'b1;
				end else begin
					st_nxt = LD_DONE;
				end
			end
			LD_SIG: begin
				if (ee_nack) begin
					st_nxt  = LD_DONE;
					req_nxt = 1'b0;
				end else if (ee_rd_ack) begin
					if (ee_rd_data == SIG_VALUE) begin
						st_nxt   = LD_DATA;
						addr_nxt = EE_AW'(CFG_ADDR);
					end else begin
						st_nxt  = LD_DONE;
						req_nxt = 1'b0;
					end
				end
			end
			LD_DATA: begin
				if (ee_nack) begin
					st_nxt  = LD_DONE;
					req_nxt = 1'b0;
				end else if (ee_rd_ack) begin
					img_nxt  = {img_r[CFG_BYTES*8-9:0], ee_rd_data};
					addr_nxt = addr_r + 1'b1;      // 8-bit wrap
					if (addr_r == EE_AW'(CFG_ADDR + CFG_BYTES - 1)) begin
						st_nxt  = LD_DONE;
						req_nxt = 1'b0;
						cfg_nxt = dev_cfg_t'(
							{img_r[CFG_BYTES*8-9:0], ee_rd_data}
							[CFG_W-1:0]);
					end
				end
			end
			LD_DONE: req_nxt = 1'b0;
			default: st_nxt = LD_IDLE;
		endcase
	end

	// Loader registers; ROM image is a constant so reset may load it
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r   <= LD_IDLE;
			cfg_r  <= ROM;
			img_r  <= '0;
			addr_r <= '0;
			req_r  <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			cfg_r  <= cfg_nxt;
			img_r  <= img_nxt;
			addr_r <= addr_nxt;
			req_r  <= req_nxt;
		end
	end

	// Sense pin synchroniser: change counts when stages two and three agree
	always_comb begin
		sense_nxt = sense_r;
		if (sense_sync_r[1] == sense_sync_r[2])
			sense_nxt = sense_sync_r[2];
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sense_sync_r <= '0;
			sense_r      <= 1'b0;
		end else begin
			sense_sync_r <= {sense_sync_r[1:0], bus_power_sense};
			sense_r      <= sense_nxt;
		end
	end

	// Pull-up held off until configuration settles to avoid a false attach
	assign dp_pullup_en = cfg_done &&
		(cfg_r.sense_en ? sense_r : 1'b1);
	assign self_powered = cfg_r.self_powered;
	assign cfg_done     = (st_r == LD_DONE);
	assign ee_rd_req    = req_r;
	assign ee_rd_addr   = addr_r;

	// Rate window test; registered so the flag is a clean data output
	always_comb begin
		baud_nxt = (baud_req >= 32'(BAUD_MIN)) &&
			(baud_req <= 32'(BAUD_MAX));
	end

	// A request outside the window is flagged, never clamped
	// The flag trails the request by one clock
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			baud_r <= 1'b0;
		end else begin
			baud_r <= baud_nxt;
		end
	end

	assign baud_ok = baud_r;

	// Per-pin settings pulled out of the live configuration image
	assign pcfg[0] = cfg_r.a4;
	assign pcfg[1] = cfg_r.a5;
	assign pcfg[2] = cfg_r.a6;
	assign pcfg[3] = cfg_r.b6;

	// Active-sense level of each pin's function, then its polarity.
	// EEPROM pins are owned by the serial engine while selected, so
	// their levels here only matter once the loader has finished.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			assign lvl[gi] = fn_level(pcfg[gi].fn, modem_out[gi], cfg_r,
				usb_state, tx_active, rx_active) ^ pcfg[gi].invert;
		end
	endgenerate

	// Pin inputs cross in from outside: three stages, and a level only
	// counts once stages two and three agree, so a single metastable
	// or glitchy sample never reaches the modem inputs.
	always_comb begin
		pin_lvl_nxt = pin_lvl_r;
		for (int i = 0; i < 4; i++) begin
			if (pin_s1_r[i] == pin_s2_r[i])
				pin_lvl_nxt[i] = pin_s2_r[i];
		end
	end

	// Input chain registers; cleared so no false edge is seen at start
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s0_r  <= '0;
			pin_s1_r  <= '0;
			pin_s2_r  <= '0;
			pin_lvl_r <= '0;
		end else begin
			pin_s0_r  <= pin_in;
			pin_s1_r  <= pin_s0_r;
			pin_s2_r  <= pin_s1_r;
			pin_lvl_r <= pin_lvl_nxt;
		end
	end

	// Pin drive and input sense per pin: polarity first, then mode.
	// Open-drain pins only ever pull low; the high level comes from
	// the board pull-up, which lets the charger side use another rail.
	// Nothing is driven before the configuration has settled.
	always_comb begin
		out_nxt = '0;
		oe_nxt  = '0;
		mdm_nxt = '0;
		for (int i = 0; i < 4; i++) begin
			out_nxt[i] = pcfg[i].open_drain ? 1'b0 : lvl[i];
			oe_nxt[i]  = cfg_done &&
				(pcfg[i].open_drain ? !lvl[i] : 1'b1);
			mdm_nxt[i] = pin_lvl_r[i] ^ pcfg[i].invert;
		end
	end

	// Pin output registers; released while reset holds
	// A one-clock lag on state changes is harmless to the charger side
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_r <= '0;
			oe_r  <= '0;
			mdm_r <= '0;
		end else begin
			out_r <= out_nxt;
			oe_r  <= oe_nxt;
			mdm_r <= mdm_nxt;
		end
	end

	// Data outputs come straight from their registers
	assign pin_out  = out_r;
	assign pin_oe   = oe_r;
	assign modem_in = mdm_r;
endmodule
`default_nettype wire

// file: testbench/pin_sig_assertions.sv
`default_nettype none
module pin_sig_assertions
	import usb_pin_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic [31:0] baud_req,
	input wire logic        baud_ok,
	input wire logic        dp_pullup_en,
	input wire logic        cfg_done,
	input wire logic        ee_rd_req,
	input wire logic [7:0]  ee_rd_addr,
	input wire logic        ee_rd_ack,
	input wire logic [7:0]  ee_rd_data,
	input wire logic        ee_nack
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Signature byte answered on the first read
	sequence sig_ack;
		ee_rd_req && ee_rd_ack && ee_rd_addr == 8'h00;
	endsequence
	a_baud_range: assert property (
		baud_req >= 1 && baud_req <= 32'h0001_c200 |=> baud_ok)
		else $error("baud flag wrong");
	a_baud_reject: assert property (
		!(baud_req >= 1 && baud_req <= 32'h0001_c200) |=> !baud_ok)
		else $error("baud flag set out of range");
	a_pullup_gate: assert property (!cfg_done |-> !dp_pullup_en)
		else $error("pull-up before config");
	a_sig_good: assert property (
		sig_ack ##0 ee_rd_data == SIG_VALUE |-> ##[1:2] ee_rd_addr == 8'h01)
		else $error("no step after signature");
	a_sig_bad: assert property (
		sig_ack ##0 ee_rd_data != SIG_VALUE |-> ##[1:2] !ee_rd_req)
		else $error("load goes on after bad signature");
	a_nack_stop: assert property (
		ee_rd_req && ee_nack |-> ##[1:2] !ee_rd_req)
		else $error("load goes on after nack");
	a_addr_range: assert property (ee_rd_req |-> ee_rd_addr <= 8'h04)
		else $error("read address out of image");
	a_load_done: assert property (
		ee_rd_req && ee_rd_ack && ee_rd_addr == 8'h04 |-> ##[1:2] cfg_done)
		else $error("done missing after last byte");
	a_idle_after: assert property (cfg_done |-> !ee_rd_req)
		else $error("read while done");
endmodule
bind usb_state_pin_signaling pin_sig_assertions chk (.sys_clk, .reset_n,
	.baud_req, .baud_ok, .dp_pullup_en, .cfg_done, .ee_rd_req, .ee_rd_addr,
	.ee_rd_ack, .ee_rd_data, .ee_nack);
`default_nettype wire

// file: testbench/ee_model.sv
`default_nettype none
module ee_model
	import usb_pin_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic [1:0] mode,
	input  wire logic       ee_rd_req,
	input  wire logic [7:0] ee_rd_addr,
	output var  logic       ee_rd_ack = 1'b0,
	output var  logic [7:0] ee_rd_data = 8'h00,
	output var  logic       ee_nack = 1'b0
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0]  wait_r = 2'h0;
	logic [31:0] image  = 32'h0079_f36e;
	// Mode 0 good image, 1 bad signature, 2 absent; a read after an odd-address read answers slowly
	always @(posedge sys_clk) begin
		ee_rd_ack <= 1'b0;
		ee_nack <= 1'b0;
		ee_rd_data <= ~ee_rd_data; // Idle data keeps moving
		if (ee_rd_req && !ee_rd_ack && !ee_nack) begin
			if (wait_r != 2'h0) begin
				wait_r <= wait_r - 2'h1;
			end else begin
				wait_r <= {ee_rd_addr[0], 1'b0};
				ee_nack <= mode == 2'h2;
				ee_rd_ack <= mode != 2'h2;
				ee_rd_data <= ee_rd_addr == 8'h00 ?
					(mode == 2'h1 ? 8'ha5 : SIG_VALUE) :
					image[{3'h4 - ee_rd_addr[2:0], 3'h0} +: 8];
			end
		end
	end
endmodule
`default_nettype wire

// file: testbench/usb_state_pin_signaling_test.sv
`default_nettype none
module usb_state_pin_signaling_test
	import usb_pin_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        sys_clk = 0, reset_n = 0, tx_active = 0, rx_active = 0;
	logic        bus_power_sense = 0, ee_rd_ack, ee_nack, ee_rd_req, chk = 0;
	logic        cfg_done, dp_pullup_en, self_powered, baud_ok;
	usb_state_t  usb_state = '0;
	logic [7:0]  ee_rd_data, ee_rd_addr;
	logic [3:0]  pin_in = '0, modem_out = '0, modem_in, pin_out, pin_oe;
	logic [31:0] baud_req = 32'h0000_0001, seed = 32'hacdf_277d;
	logic [1:0]  mode = '0;
	logic [15:0] q[$], seen, note;
	int          n_errors = 0, checks_done = 0;
	always #12.5 sys_clk = ~sys_clk;
	usb_state_pin_signaling #(.ROM_CFG(24'h92_2280)) dut (.sys_clk, .reset_n,
		.usb_state, .tx_active, .rx_active, .bus_power_sense, .ee_rd_ack,
		.ee_rd_data, .ee_nack, .pin_in, .modem_out, .baud_req, .dp_pullup_en,
		.self_powered, .ee_rd_req, .ee_rd_addr, .cfg_done, .baud_ok,
		.modem_in, .pin_out, .pin_oe);
	ee_model eem (.sys_clk, .mode, .ee_rd_req, .ee_rd_addr, .ee_rd_ack,
		.ee_rd_data, .ee_nack);
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t outputs %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		if (n_errors == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Settled outputs compared against the oldest note
	always @(negedge sys_clk) if (chk) begin
		seen = {1'b0, self_powered, dp_pullup_en, baud_ok, modem_in, pin_out,
			pin_oe};
		note = q.pop_front();
		check(seen[15:8], note[15:8]);
		check(seen[7:0], note[7:0]);
	end
	// Each load outcome: good image, bad signature, absent part
	initial begin
		for (int m = 0; m < 3; m++) begin
			reset_n <= 0;
			mode <= m[1:0];
			repeat (8) @(posedge sys_clk);
			reset_n <= 1;
			for (int i = 0; i < 60 && cfg_done !== 1'b1; i++) @(posedge sys_clk);
			if (cfg_done !== 1'b1) begin
				n_errors++;
				results();
			end
			for (int i = 0; i < 12; i++) begin
				seed = xs(seed);
				bus_power_sense <= seed[0];
				pin_in <= seed[4:1];
				{usb_state, tx_active, rx_active, modem_out} <= seed[13:5];
				baud_req <= i < 2 ? 32'(i) : 32'h0001_c1f6 + seed[19:15];
				repeat (5) @(posedge sys_clk);
				q.push_back({1'b0, m == 0, m == 0 || seed[0], baud_req >= 1 &&
					baud_req <= 32'h0001_c200, seed[4:1] ^ (m == 0 ? 4'hd : 4'h0),
					m == 0 ? {seed[12], 1'b0, !seed[12], 1'b0} :
					{seed[8], seed[10], seed[9], seed[10]},
					m == 0 ? {1'b1, seed[11], 1'b1, seed[13]} : 4'hf});
				chk <= 1;
				@(posedge sys_clk);
				chk <= 0;
			end
		end
		results();
	end
endmodule
`default_nettype wire
